// File: logic/bsl_crc.sv
// Word-wide MSB-first CRC-32 engine
`timescale 1ns/1ps
`default_nettype none
module bsl_crc
  import bsl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Sequencer side
  bsl_crc_if.engine cif
);

  logic [31:0] crc;
  logic [31:0] next_crc;

  // One whole word per clock, most significant bit first
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] w);
    logic [31:0] r;
    logic fb;
    r = c;
    for (int i = 31; i >= 0; i--)
    begin
      fb = r[31] ^ w[i];
      r = {r[30:0], 1'b0};
      if (fb)
        r = r ^ CRC_POLY;
    end
    return r;
  endfunction

  // Clear outranks a word fed in the same cycle
  always_comb
  begin
    next_crc = crc;
    if (cif.clr)
      next_crc = CRC_INIT;
    else if (cif.en)
      next_crc = crc_step(crc, cif.word);
  end

  // Running remainder
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      crc <= CRC_INIT;
    else
      crc <= next_crc;
  end

  assign cif.crc = crc;

endmodule
`default_nettype wire

// File: logic/bsl_loader.sv
// Boot security loader: page-zero parameter checks, locks and access gate
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1 - Lower bank retain keeps low 12 kB
// R2 - Upper bank retain keeps next 16 kB
// R3 - Protected info reads answer bus error
// R4 - Info window reads are allowed
// R5 - No program or erase of info space
// R6 - Window holds revision, maker and unique IDs
// R7 - Verify image or enter downloader per pin
// R8 - Fetch key hash from page zero
// R9 - Unprogrammed valid hash leaves debug open
// R10 - Programmed hash locks debug port
// R11 - Key hash valid only with matching checksum
// R12 - Key match full rights, else write only
// R13 - No-write marker locks debug port
// R14 - Code length bounds image check
// R15 - Copy protection word into controller
// R16 - Each protection bit locks four pages
// R17 - Run loaded code only after authentication
// R18 - Image CRC-32 at page end, ones skip
// R19 - Bad image CRC denies all but mass erase
// R20 - Pin low downloader, high user code
// R21 - Release nothing before checks finish
module bsl_loader
  import bsl_pkg::*;
#(
  parameter logic [31:0] KERNEL_REV = 32'h0000_0001, // arbitrary value
  parameter logic [95:0] MAKER_ID = 96'h0000_0000_0000_0000_0000_00A5, // arbitrary value
  parameter logic [127:0] UNIQUE_ID = 128'h0000_0000_0000_0000_0000_0000_0000_005A // arbitrary
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Boot strap
  input wire logic boot_select_pin,
  // Flash read port
  output logic flash_rd_req,
  output logic [31:0] flash_rd_addr,
  input wire logic flash_rd_valid,
  input wire logic [31:0] flash_rd_data,
  // Flash controller write protection
  output logic [31:0] wp_word,
  output logic wp_load,
  // Boot outcome
  output logic boot_done,
  output logic debug_enable,
  output logic cpu_release_user,
  output logic downloader_mode,
  output logic user_flash_open,
  // Second stage loader
  input wire logic stage2_hash_valid,
  input wire logic [127:0] stage2_hash,
  input wire logic stage2_auth_ok,
  output logic stage2_full_perm,
  output logic stage2_write_perm,
  output logic stage2_run_enable,
  // User access gate
  input wire logic ua_req,
  input wire logic [31:0] ua_addr,
  input wire bsl_acc_type ua_kind,
  output logic ua_ack,
  output logic ua_pass,
  output logic ua_error,
  output logic [31:0] ua_rdata,
  // Instruction SRAM retention
  input wire logic lower_bank_retain,
  input wire logic upper_bank_retain,
  input wire logic [31:0] ret_query_addr,
  output logic lower_keep,
  output logic upper_keep,
  output logic ret_query_hit
);

  bsl_crc_if cif ();

  bsl_crc u_crc (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cif(cif)
  );

  bsl_state_type state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [31:0] addr, next_addr;
  logic [31:0] p [0:7];
  logic [31:0] next_p [0:7];
  logic [31:0] img_crc, next_img_crc;
  logic boot_sel, next_boot_sel;
  logic blank, next_blank;
  logic hash_ones, next_hash_ones;
  logic kcrc_ok, next_kcrc_ok;
  logic no_write_setting, next_no_write_setting;
  logic crc_ok, next_crc_ok;
  logic [31:0] next_wp_word;
  logic next_wp_load;
  logic dbg_open;

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Stored image CRC sits in the last word of page N
  function automatic logic [31:0] crc_addr_of(input logic [31:0] len);
    return {13'h0000, len[7:0], PAGE_CRC_OFS};
  endfunction

  // Protection bit covers four pages; pages past the word stay open
  function automatic logic page_locked(input logic [31:0] wp, input logic [31:0] a);
    logic [7:0] page;
    page = a[18:11];
    return page[7] ? 1'b0 : wp[page[6:2]];
  endfunction

  assign cif.clr = (state == ST_SAMPLE) || (state == ST_CHECK);
  assign cif.en = (state == ST_KEYCRC) || ((state == ST_IMAGE) && flash_rd_valid);
  assign cif.word = (state == ST_KEYCRC) ? p[{1'b0, cnt[1:0]}] : flash_rd_data;
  assign flash_rd_req = (state == ST_PARAM) || (state == ST_CRCRD) || (state == ST_IMAGE);
  assign flash_rd_addr = addr;

  // Boot sequencer: fetch, check, verify, then settle
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_addr = addr;
    next_p = p;
    next_img_crc = img_crc;
    next_boot_sel = boot_sel;
    next_blank = blank;
    next_hash_ones = hash_ones;
    next_kcrc_ok = kcrc_ok;
    next_no_write_setting = no_write_setting;
    next_crc_ok = crc_ok;
    next_wp_word = wp_word;
    next_wp_load = 1'b0;
    unique case (state)
      ST_SAMPLE:
      begin
        next_boot_sel = boot_select_pin; // R7
        next_addr = PARAM_BASE; // R8
        next_cnt = 4'h0;
        next_state = ST_PARAM;
      end
      ST_PARAM:
        if (flash_rd_valid)
        begin
          next_p[cnt[2:0]] = flash_rd_data; // R8
          next_addr = addr + WORD_STEP;
          next_cnt = cnt + 4'h1;
          if (cnt == PARAM_LAST)
          begin
            next_cnt = 4'h0;
            next_state = ST_KEYCRC;
          end
        end
      ST_KEYCRC:
      begin
        next_cnt = cnt + 4'h1;
        if (cnt == HASH_LAST)
          next_state = ST_CHECK;
      end
      ST_CHECK:
      begin
        next_hash_ones = (p[0] & p[1] & p[2] & p[3]) == ALL_ONES;
        next_kcrc_ok = cif.crc == p[IDX_KEY_CRC]; // R11
        next_no_write_setting = p[IDX_NO_WRITE] == NO_WRITE_MARKER; // R13
        next_blank = (p[0] & p[1] & p[2] & p[3] & p[4] & p[5] & p[6] & p[7]) == ALL_ONES;
        next_wp_word = p[IDX_WR_PROT]; // R15
        next_wp_load = 1'b1; // R15
        next_crc_ok = 1'b0;
        if (next_blank)
        begin
          next_crc_ok = 1'b1;
          next_state = ST_DONE;
        end
        else if (p[IDX_CODE_LEN] > MAX_LAST_PAGE) // R14
          next_state = ST_DONE;
        else
        begin
          next_addr = crc_addr_of(p[IDX_CODE_LEN]); // R18
          next_state = ST_CRCRD;
        end
      end
      ST_CRCRD:
        if (flash_rd_valid)
        begin
          next_img_crc = flash_rd_data;
          next_addr = FLASH_BASE;
          if (flash_rd_data == ALL_ONES) // R18
          begin
            next_crc_ok = 1'b1;
            next_state = ST_DONE;
          end
          else
            next_state = ST_IMAGE;
        end
      ST_IMAGE:
        if (flash_rd_valid)
        begin
          next_addr = addr + WORD_STEP;
          if (next_addr == crc_addr_of(p[IDX_CODE_LEN])) // R14
            next_state = ST_VERIFY;
        end
      ST_VERIFY:
      begin
        next_crc_ok = cif.crc == img_crc; // R18
        next_state = ST_DONE;
      end
      ST_DONE:
        next_state = ST_DONE;
    endcase
  end

  // Sequencer registers; parameters cleared so nothing is trusted early
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_SAMPLE;
      cnt <= 4'h0;
      addr <= 32'h0000_0000;
      for (int i = 0; i < 8; i++)
        p[i] <= 32'h0000_0000;
      img_crc <= 32'h0000_0000;
      boot_sel <= 1'b0;
      blank <= 1'b0;
      hash_ones <= 1'b0;
      kcrc_ok <= 1'b0;
      no_write_setting <= 1'b0;
      crc_ok <= 1'b0;
      wp_word <= 32'h0000_0000;
      wp_load <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      addr <= next_addr;
      p <= next_p;
      img_crc <= next_img_crc;
      boot_sel <= next_boot_sel;
      blank <= next_blank;
      hash_ones <= next_hash_ones;
      kcrc_ok <= next_kcrc_ok;
      no_write_setting <= next_no_write_setting;
      crc_ok <= next_crc_ok;
      wp_word <= next_wp_word;
      wp_load <= next_wp_load;
    end
  end

  // Blank part opens debug for first programming
  assign dbg_open = blank || (hash_ones && kcrc_ok && !no_write_setting); // R9 R10 R13

  // Window word select by word offset
  function automatic logic [31:0] win_word(input logic [2:0] w);
    logic [31:0] r;
    unique case (w)
      3'h0: r = KERNEL_REV;
      3'h1: r = MAKER_ID[31:0];
      3'h2: r = MAKER_ID[63:32];
      3'h3: r = MAKER_ID[95:64];
      3'h4: r = UNIQUE_ID[31:0];
      3'h5: r = UNIQUE_ID[63:32];
      3'h6: r = UNIQUE_ID[95:64];
      3'h7: r = UNIQUE_ID[127:96];
    endcase
    return r;
  endfunction

  logic next_boot_done, next_debug_enable, next_cpu_release, next_dl_mode, next_open;
  logic next_full, next_wr, next_run;
  logic next_ack, next_pass, next_err;
  logic [31:0] next_rdata;
  logic next_lkeep, next_ukeep, next_rhit;
  logic done;

  assign done = state == ST_DONE;

  // Outcome, loader rights, access gate and retention
  always_comb
  begin
    next_boot_done = done; // R21
    next_debug_enable = done && dbg_open; // R9 R10 R13 R21
    next_cpu_release = done && !blank && boot_sel && crc_ok; // R7 R19 R20 R21
    next_dl_mode = done && (blank || !boot_sel); // R20
    next_open = done && crc_ok; // R19
    next_full = stage2_full_perm;
    next_wr = stage2_write_perm;
    next_run = stage2_run_enable;
    if (downloader_mode && stage2_hash_valid)
    begin
      next_full = stage2_hash == {p[3], p[2], p[1], p[0]}; // R12
      next_wr = 1'b1; // R12
    end
    if (downloader_mode && stage2_auth_ok)
      next_run = 1'b1; // R17
    next_ack = ua_req;
    next_pass = 1'b0;
    next_err = 1'b0;
    next_rdata = 32'h0000_0000;
    if (ua_req)
    begin
      if (!done)
        next_err = 1'b1; // R21
      else if (in_range(ua_addr, INFO_LO, INFO_HI))
      begin
        if ((ua_kind == ACC_READ) && in_range(ua_addr, WIN_LO, WIN_HI))
          next_rdata = win_word(ua_addr[4:2]); // R4 R6
        else
          next_err = 1'b1; // R3 R5
      end
      else if (ua_kind == ACC_MASS_ERASE)
        next_pass = 1'b1; // R19
      else if (!crc_ok)
        next_err = 1'b1; // R19
      else if ((ua_kind != ACC_READ) && page_locked(wp_word, ua_addr))
        next_err = 1'b1; // R16
      else
        next_pass = 1'b1;
    end
    next_lkeep = lower_bank_retain; // R1
    next_ukeep = upper_bank_retain; // R2
    next_rhit = (lower_bank_retain && in_range(ret_query_addr, RET_LOW_LO, RET_LOW_HI)) ||
                (upper_bank_retain && in_range(ret_query_addr, RET_UP_LO, RET_UP_HI));
  end

  // Output registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_done <= 1'b0;
      debug_enable <= 1'b0;
      cpu_release_user <= 1'b0;
      downloader_mode <= 1'b0;
      user_flash_open <= 1'b0;
      stage2_full_perm <= 1'b0;
      stage2_write_perm <= 1'b0;
      stage2_run_enable <= 1'b0;
      ua_ack <= 1'b0;
      ua_pass <= 1'b0;
      ua_error <= 1'b0;
      ua_rdata <= 32'h0000_0000;
      lower_keep <= 1'b0;
      upper_keep <= 1'b0;
      ret_query_hit <= 1'b0;
    end
    else
    begin
      boot_done <= next_boot_done;
      debug_enable <= next_debug_enable;
      cpu_release_user <= next_cpu_release;
      downloader_mode <= next_dl_mode;
      user_flash_open <= next_open;
      stage2_full_perm <= next_full;
      stage2_write_perm <= next_wr;
      stage2_run_enable <= next_run;
      ua_ack <= next_ack;
      ua_pass <= next_pass;
      ua_error <= next_err;
      ua_rdata <= next_rdata;
      lower_keep <= next_lkeep;
      upper_keep <= next_ukeep;
      ret_query_hit <= next_rhit;
    end
  end

  // Checks on the design's own outputs
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_dbg_lock;
    done && !blank && !hash_ones |=> !debug_enable;
  endproperty
  a_dbg_lock: assert property (p_dbg_lock) else $error("debug open with programmed hash"); // R10

  property p_dbg_open;
    done && hash_ones && kcrc_ok && !no_write_setting |=> debug_enable;
  endproperty
  a_dbg_open: assert property (p_dbg_open) else $error("debug locked with open hash"); // R9

  property p_no_write;
    done && !blank && no_write_setting |=> !debug_enable;
  endproperty
  a_no_write: assert property (p_no_write) else $error("debug open with no-write marker"); // R13

  property p_prot_read;
    ua_req && in_range(ua_addr, PROT_LO, PROT_HI) |=> ua_ack && ua_error && !ua_pass;
  endproperty
  a_prot_read: assert property (p_prot_read) else $error("protected read not refused"); // R3

  property p_win_read;
    done && ua_req && ua_kind == ACC_READ && in_range(ua_addr, WIN_LO, WIN_HI)
      |=> ua_ack && !ua_error;
  endproperty
  a_win_read: assert property (p_win_read) else $error("window read refused"); // R4

  property p_info_write;
    ua_req && ua_kind != ACC_READ && in_range(ua_addr, INFO_LO, INFO_HI) |=> ua_error;
  endproperty
  a_info_write: assert property (p_info_write) else $error("info space altered"); // R5

  property p_wp_copy;
    state == ST_CHECK |=> wp_load && wp_word == p[IDX_WR_PROT];
  endproperty
  a_wp_copy: assert property (p_wp_copy) else $error("protection word not copied"); // R15

  property p_early;
    !done |=> !debug_enable && !cpu_release_user;
  endproperty
  a_early: assert property (p_early) else $error("release before checks done"); // R21

  property p_bad_crc;
    cpu_release_user |-> user_flash_open && $past(crc_ok);
  endproperty
  a_bad_crc: assert property (p_bad_crc) else $error("user code run with bad crc"); // R19

  property p_stage2_run;
    $rose(stage2_run_enable) |-> $past(stage2_auth_ok) && $past(downloader_mode);
  endproperty
  a_stage2_run: assert property (p_stage2_run) else $error("loader run without auth"); // R17

  c_blank: cover property (done && blank ##1 downloader_mode);
  c_user: cover property (state == ST_VERIFY ##2 cpu_release_user);
  c_prot: cover property (ua_req && in_range(ua_addr, PROT_LO, PROT_HI) ##1 ua_error);

endmodule
`default_nettype wire

// File: pkg/bsl_crc_if.sv
// Link between the boot sequencer and its checksum engine
`timescale 1ns/1ps
`default_nettype none
interface bsl_crc_if;
  logic clr;
  logic en;
  logic [31:0] word;
  logic [31:0] crc;
  modport seq (output clr, output en, output word, input crc);
  modport engine (input clr, input en, input word, output crc);
endinterface
`default_nettype wire

// File: pkg/bsl_pkg.sv
// Constants, encodings and state codes of the boot security loader
package bsl_pkg;

  // Page-zero parameter block
  localparam logic [31:0] PARAM_BASE = 32'h0000_0180;
  localparam logic [3:0] PARAM_LAST = 4'h7;
  localparam logic [3:0] HASH_LAST = 4'h3;
  localparam logic [2:0] IDX_KEY_CRC = 3'h4;
  localparam logic [2:0] IDX_CODE_LEN = 3'h5;
  localparam logic [2:0] IDX_NO_WRITE = 3'h6;
  localparam logic [2:0] IDX_WR_PROT = 3'h7;

  // Parameter values
  localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
  localparam logic [31:0] NO_WRITE_MARKER = 32'h4E6F_5772;
  localparam logic [31:0] MAX_LAST_PAGE = 32'h0000_00FF;
  localparam logic [10:0] PAGE_CRC_OFS = 11'h7FC;
  localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;

  // Checksum engine
  localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;

  // Device information space
  localparam logic [31:0] INFO_LO = 32'h0008_0000;
  localparam logic [31:0] INFO_HI = 32'h0008_0FFF;
  localparam logic [31:0] PROT_LO = 32'h0008_0F00;
  localparam logic [31:0] PROT_HI = 32'h0008_0FFF;
  localparam logic [31:0] WIN_LO = 32'h0008_0EE0;
  localparam logic [31:0] WIN_HI = 32'h0008_0EFF;

  // Instruction SRAM retention banks
  localparam logic [31:0] RET_LOW_LO = 32'h1000_0000;
  localparam logic [31:0] RET_LOW_HI = 32'h1000_2FFF;
  localparam logic [31:0] RET_UP_LO = 32'h1000_3000;
  localparam logic [31:0] RET_UP_HI = 32'h1000_6FFF;

  // User access kinds
  typedef enum logic [1:0] {
    ACC_READ = 2'b00,
    ACC_WRITE = 2'b01,
    ACC_PAGE_ERASE = 2'b10,
    ACC_MASS_ERASE = 2'b11
  } bsl_acc_type;

  // Boot sequencer states
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'b000,
    ST_PARAM = 3'b001,
    ST_KEYCRC = 3'b010,
    ST_CHECK = 3'b011,
    ST_CRCRD = 3'b100,
    ST_IMAGE = 3'b101,
    ST_VERIFY = 3'b110,
    ST_DONE = 3'b111
  } bsl_state_type;

endpackage

// File: tb/bsl_flash_model.sv
// Behavioural flash array that answers the loader's word reads
`timescale 1ns/1ps
`default_nettype none
module bsl_flash_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Answer delay in cycles
  input wire logic [3:0] lat,
  // Read port
  input wire logic flash_rd_req,
  input wire logic [31:0] flash_rd_addr,
  output logic flash_rd_valid,
  output logic [31:0] flash_rd_data
);
  // Page zero only; other addresses read back a pattern
  logic [31:0] mem [0:511];
  logic [3:0] cnt;

  // Data toggles outside a valid beat, so a stale word never matches by luck
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 4'h0;
      flash_rd_valid <= 1'b0;
      flash_rd_data <= 32'h0000_0000;
    end
    else if (flash_rd_req && !flash_rd_valid && cnt == lat)
    begin
      cnt <= 4'h0;
      flash_rd_valid <= 1'b1;
      flash_rd_data <= (flash_rd_addr < 32'h0000_0800) ? mem[flash_rd_addr[10:2]] : ~flash_rd_addr;
    end
    else
    begin
      cnt <= (flash_rd_req && !flash_rd_valid) ? cnt + 4'h1 : 4'h0;
      flash_rd_valid <= 1'b0;
      flash_rd_data <= ~flash_rd_data;
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the boot security loader
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import bsl_pkg::*;
;
  localparam logic [31:0] REV = 32'h0000_00C3; // arbitrary value
  localparam logic [95:0] MID = 96'h0000_0011_0000_0022_0000_0033; // arbitrary value
  localparam logic [127:0] UID = 128'h0000_0044_0000_0055_0000_0066_0000_0077; // arbitrary value
  localparam logic [31:0] WPW = 32'h0000_0002;
  localparam logic [127:0] HK = 128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978;
  localparam logic [127:0] H1 = {4{ALL_ONES}};

  logic core_clk, rst_n, boot_select_pin, flash_rd_req, flash_rd_valid, wp_load, boot_done;
  logic debug_enable, cpu_release_user, downloader_mode, user_flash_open;
  logic stage2_hash_valid, stage2_auth_ok;
  logic stage2_full_perm, stage2_write_perm, stage2_run_enable;
  logic ua_req, ua_ack, ua_pass, ua_error, lower_bank_retain, upper_bank_retain;
  logic lower_keep, upper_keep, ret_query_hit;
  logic [31:0] flash_rd_addr, flash_rd_data, wp_word, ua_addr, ua_rdata, ret_query_addr, wp_got;
  logic [127:0] stage2_hash;
  logic [3:0] lat;
  logic [4:0] outs;
  bsl_acc_type ua_kind;
  int mismatches, n_compared, wp_cnt, early;

  assign outs = {boot_done, debug_enable, cpu_release_user, downloader_mode, user_flash_open};

  bsl_loader #(.KERNEL_REV(REV), .MAKER_ID(MID), .UNIQUE_ID(UID)) uut (
    .core_clk, .rst_n, .boot_select_pin, .flash_rd_req, .flash_rd_addr, .flash_rd_valid,
    .flash_rd_data, .wp_word, .wp_load, .boot_done, .debug_enable, .cpu_release_user,
    .downloader_mode, .user_flash_open, .stage2_hash_valid, .stage2_hash, .stage2_auth_ok,
    .stage2_full_perm, .stage2_write_perm, .stage2_run_enable, .ua_req, .ua_addr, .ua_kind,
    .ua_ack,
    .ua_pass, .ua_error, .ua_rdata, .lower_bank_retain, .upper_bank_retain, .ret_query_addr,
    .lower_keep, .upper_keep, .ret_query_hit);

  bsl_flash_model flash (.core_clk, .rst_n, .lat, .flash_rd_req, .flash_rd_addr,
    .flash_rd_valid, .flash_rd_data);

  // Free-running 40 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Flags a debug, release or downloader opening before checks end; records each protection load
  always @(posedge core_clk)
  begin
    if (rst_n === 1'b1 && boot_done !== 1'b1 &&
        (debug_enable | cpu_release_user | downloader_mode) === 1'b1)
      early++;
    if (wp_load === 1'b1)
    begin
      wp_cnt++;
      wp_got = wp_word;
    end
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Reference checksum, kept apart from the engine under test
  function automatic logic [31:0] crc_w(input logic [31:0] c, input logic [31:0] w);
    logic [31:0] r;
    r = c;
    for (int b = 31; b >= 0; b--)
      r = {r[30:0], 1'b0} ^ ((r[31] ^ w[b]) ? CRC_POLY : 32'h0000_0000);
    return r;
  endfunction

  // Page zero: hash, checksum xor ckx, length, marker, protection, image CRC mode
  task automatic load(input logic [127:0] h, input logic [31:0] ckx, input logic [31:0] nw,
                      input logic [31:0] len, input logic [1:0] cm);
    logic [31:0] c;
    for (int i = 0; i < 512; i++)
      flash.mem[i] = 32'h5A00_0000 + 32'(i);
    c = CRC_INIT;
    for (int i = 0; i < 4; i++)
    begin
      flash.mem[96 + i] = h[32 * i +: 32];
      c = crc_w(c, h[32 * i +: 32]);
    end
    flash.mem[100] = c ^ ckx;
    flash.mem[101] = len;
    flash.mem[102] = nw;
    flash.mem[103] = WPW;
    c = CRC_INIT;
    for (int i = 0; i < 511; i++)
      c = crc_w(c, flash.mem[i]);
    flash.mem[511] = (cm == 2'd0) ? c : (cm == 2'd1) ? ~c : ALL_ONES;
  endtask

  // One user access; answer sampled in the cycle after it is taken
  task automatic acc(input bsl_acc_type k, input logic [31:0] a, input logic [1:0] pe,
                     input logic [31:0] d);
    ua_req = 1'b1;
    ua_addr = a;
    ua_kind = k;
    @(negedge core_clk);
    ua_req = 1'b0;
    chk({ua_ack, ua_pass, ua_error, ua_rdata}, {1'b1, pe, d});
    @(negedge core_clk);
  endtask

  // Reset, strap and wait for the checks to finish
  task automatic boot(input logic pin, input logic [3:0] l);
    int i;
    rst_n = 1'b0;
    boot_select_pin = pin;
    lat = l;
    wp_cnt = 0;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    acc(ACC_READ, 32'h0000_0100, 2'b01, 32'h0000_0000);
    for (i = 0; i < 4000 && boot_done !== 1'b1; i++)
      @(negedge core_clk);
  endtask

  task automatic stage2(input logic [127:0] h, input logic m);
    chk(stage2_run_enable, 1'b0);
    stage2_hash = h;
    stage2_hash_valid = 1'b1;
    @(negedge core_clk);
    stage2_hash_valid = 1'b0;
    chk({stage2_write_perm, stage2_full_perm}, {1'b1, m});
    stage2_auth_ok = 1'b1;
    @(negedge core_clk);
    stage2_auth_ok = 1'b0;
    chk(stage2_run_enable, 1'b1);
  endtask

  task automatic ret(input logic [31:0] a, input logic lo, input logic up, input logic hit);
    ret_query_addr = a;
    lower_bank_retain = lo;
    upper_bank_retain = up;
    @(negedge core_clk);
    chk({lower_keep, upper_keep, ret_query_hit}, {lo, up, hit});
  endtask

  // Hang guard, well beyond the expected few thousand cycles
  initial
  begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    summarize;
  end

  // Main sequence
  initial
  begin
    {rst_n, boot_select_pin, stage2_hash_valid, stage2_auth_ok, ua_req} = 5'b0_0000;
    {lower_bank_retain, upper_bank_retain, lat} = 6'h00;
    {stage2_hash, ua_addr, ret_query_addr} = '0;
    ua_kind = ACC_READ;
    mismatches = 0;
    n_compared = 0;
    early = 0;
    @(negedge core_clk);
    for (int i = 0; i < 512; i++)
      flash.mem[i] = ALL_ONES;
    boot(1'b1, 4'h0);
    chk(outs, 5'b11011);
    load(H1, 32'h0, 32'h0, 32'h0, 2'd0);
    boot(1'b1, 4'h2);
    chk(outs, 5'b11101);
    chk({wp_cnt[7:0], wp_got}, {8'h01, WPW});
    acc(ACC_READ, WIN_LO, 2'b00, REV);
    acc(ACC_READ, 32'h0008_0EE4, 2'b00, MID[31:0]);
    acc(ACC_READ, 32'h0008_0EEC, 2'b00, MID[95:64]);
    acc(ACC_READ, 32'h0008_0EF0, 2'b00, UID[31:0]);
    acc(ACC_READ, 32'h0008_0EFC, 2'b00, UID[127:96]);
    acc(ACC_READ, 32'h0008_0F00, 2'b01, 32'h0);
    acc(ACC_READ, 32'h0008_0FFC, 2'b01, 32'h0);
    acc(ACC_READ, 32'h0008_0EDC, 2'b01, 32'h0);
    acc(ACC_WRITE, 32'h0008_0EE0, 2'b01, 32'h0);
    acc(ACC_PAGE_ERASE, 32'h0008_0000, 2'b01, 32'h0);
    acc(ACC_WRITE, 32'h0000_2000, 2'b01, 32'h0);
    acc(ACC_PAGE_ERASE, 32'h0000_3FFC, 2'b01, 32'h0);
    acc(ACC_WRITE, 32'h0000_1FFC, 2'b10, 32'h0);
    acc(ACC_WRITE, 32'h0000_4000, 2'b10, 32'h0);
    acc(ACC_READ, 32'h0000_0100, 2'b10, 32'h0);
    load(H1, 32'h0, 32'h0, 32'h0, 2'd1);
    boot(1'b1, 4'h0);
    chk(outs, 5'b11000);
    acc(ACC_READ, 32'h0000_0100, 2'b01, 32'h0);
    acc(ACC_WRITE, 32'h0000_4000, 2'b01, 32'h0);
    acc(ACC_PAGE_ERASE, 32'h0000_4000, 2'b01, 32'h0);
    acc(ACC_MASS_ERASE, 32'h0000_0000, 2'b10, 32'h0);
    load(HK, 32'h0, 32'h0, 32'h0, 2'd2);
    boot(1'b0, 4'h1);
    chk(outs, 5'b10011);
    stage2(~HK, 1'b0);
    load(H1, 32'h0, NO_WRITE_MARKER, 32'h0, 2'd0);
    boot(1'b0, 4'h0);
    chk(outs, 5'b10011);
    stage2(H1, 1'b1);
    load(H1, 32'h0000_0001, 32'h0, 32'h0, 2'd0);
    boot(1'b1, 4'h0);
    chk(outs, 5'b10101);
    load(H1, 32'h0, 32'h0, 32'h0000_0100, 2'd0);
    boot(1'b1, 4'h0);
    chk(outs, 5'b11000);
    chk(early, 0);
    ret(32'h1000_0000, 1'b1, 1'b0, 1'b1);
    ret(32'h1000_2FFF, 1'b1, 1'b0, 1'b1);
    ret(32'h1000_3000, 1'b1, 1'b0, 1'b0);
    ret(32'h1000_3000, 1'b0, 1'b1, 1'b1);
    ret(32'h1000_6FFF, 1'b0, 1'b1, 1'b1);
    ret(32'h1000_2FFF, 1'b0, 1'b1, 1'b0);
    ret(32'h1000_7000, 1'b1, 1'b1, 1'b0);
    ret(32'h0FFF_FFFC, 1'b1, 1'b1, 1'b0);
    summarize;
  end
endmodule
`default_nettype wire
